// [include/fcl_regs.vh]
// Purpose: constants for the fuse configuration loader
// Assumes: byte-wide fuse array, word-aligned Wishbone register map
// Notes: offsets are fuse indices; byte address is four times the index
`ifndef FCL_REGS_VH
`define FCL_REGS_VH
`define FCL_IDX_WDT 4'h0
`define FCL_IDX_BOD 4'h1
`define FCL_IDX_OSC 4'h2
`define FCL_IDX_TMR 4'h4
`define FCL_IDX_SYS0 4'h5
`define FCL_IDX_SYS1 4'h6
`define FCL_IDX_APP 4'h7
`define FCL_IDX_BOOT 4'h8
`define FCL_IDX_LOCK 4'hA
`define FCL_IDX_STAT 4'hC
`define FCL_NUM_FUSE 11
`define FCL_RST_WDT 8'h00
`define FCL_RST_BOD 8'h00
`define FCL_RST_OSC 8'h02
`define FCL_RST_TMR 8'h00
`define FCL_RST_SYS0 8'hF6
`define FCL_RST_SYS1 8'h07
`define FCL_RST_APP 8'h00
`define FCL_RST_BOOT 8'h00
`define FCL_RST_LOCK 8'h00
`define FCL_PIN_GPIO 2'h0
`define FCL_PIN_DEBUG 2'h1
`define FCL_PIN_RESET 2'h2
`define FCL_SYS0_BLOCK_OFF_BIT 4
`define FCL_RST_FREQ 2'h2
`define FCL_RST_SCAN 2'h3
`define FCL_BLOCK_SLOW_CYC 768
`define FCL_SLOW_DIV 6104
`define FCL_LOAD_CYC 4'hB
`endif

// [core/fcl_block_timer.v]
// Purpose: counts slow oscillator ticks for the post power-on write block
// Assumes: slow_tick is a one-cycle pulse per slow oscillator cycle
// Notes: stays idle when not started
`include "fcl_regs.vh"
`default_nettype none
module fcl_block_timer (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire slow_tick,
	output reg busy_r
);
	reg [9:0] cnt_r;
	localparam [9:0] LAST_TICK = `FCL_BLOCK_SLOW_CYC - 1;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 10'h000;
			busy_r <= 1'b0;
		end else if (start) begin
			cnt_r <= 10'h000;
			busy_r <= 1'b1;
		end else if (busy_r && slow_tick) begin
			if (cnt_r == LAST_TICK) begin
				busy_r <= 1'b0;
			end
			cnt_r <= cnt_r + 10'h001;
		end
	end
endmodule
`default_nettype wire

// [core/fcl_loader.v]
// Purpose: fuse configuration loader with Wishbone read access
// Assumes: fuse array arrives on FUSE_* inputs, stable during load
// Notes: POR_FLAG marks the reset being a power-on reset
`include "fcl_regs.vh"
`default_nettype none
module fcl_loader #(
	parameter SLOW_DIV = `FCL_SLOW_DIV
) (
	input wire MCLK,
	input wire RST_N,
	input wire POR_FLAG,
	input wire [7:0] FUSE_WDT,
	input wire [7:0] FUSE_BOD,
	input wire [7:0] FUSE_OSC,
	input wire [7:0] FUSE_TMR,
	input wire [7:0] FUSE_SYS0,
	input wire [7:0] FUSE_SYS1,
	input wire [7:0] FUSE_APP,
	input wire [7:0] FUSE_BOOT,
	input wire [7:0] FUSE_LOCK,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	output reg WB_ERR_O,
	output reg LOAD_DONE,
	output reg [3:0] WDT_WINDOW,
	output reg [3:0] WDT_PERIOD,
	output reg [2:0] BROWNOUT_THRESHOLD_SEL,
	output reg BROWNOUT_SAMPLE_RATE,
	output reg [1:0] BROWNOUT_ACTIVE_MODE,
	output reg [1:0] BROWNOUT_SLEEP_MODE,
	output reg RC_TRIM_LOCK,
	output reg [1:0] RC_FREQUENCY_SELECT,
	output reg [3:0] COMPARE_PIN_OUTPUT_ENABLE,
	output reg [3:0] COMPARE_DEFAULT_LEVEL,
	output reg [1:0] SCAN_SOURCE_SELECT,
	output reg [1:0] RESET_PIN_FUNCTION,
	output reg NV_WRITE_BLOCK
);
	// ****************************************
	// reset release
	// ****************************************
	reg rst_s1_r;
	reg rst_s2_r;
	wire rst_n_i;
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rst_n_i = rst_s2_r;

	// ****************************************
	// load sequencer
	// ****************************************
	localparam ST_IDLE = 3'b001;
	localparam ST_LOAD = 3'b010;
	localparam ST_DONE = 3'b100;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [3:0] idx_r;
	reg por_r;
	reg [7:0] fuse_r [0:`FCL_NUM_FUSE-1];
	reg [7:0] fuse_in;
	reg block_start_r;
	wire block_busy;
	always @* begin
		case (idx_r)
			`FCL_IDX_WDT: fuse_in = FUSE_WDT;
			`FCL_IDX_BOD: fuse_in = FUSE_BOD;
			`FCL_IDX_OSC: fuse_in = FUSE_OSC;
			`FCL_IDX_TMR: fuse_in = FUSE_TMR;
			`FCL_IDX_SYS0: fuse_in = FUSE_SYS0;
			`FCL_IDX_SYS1: fuse_in = FUSE_SYS1;
			`FCL_IDX_APP: fuse_in = FUSE_APP;
			`FCL_IDX_BOOT: fuse_in = FUSE_BOOT;
			`FCL_IDX_LOCK: fuse_in = FUSE_LOCK;
			default: fuse_in = 8'hFF;
		endcase
	end
	always @* begin
		case (state_r)
			ST_IDLE: state_nxt = ST_LOAD;
			ST_LOAD: state_nxt = (idx_r == (`FCL_LOAD_CYC - 4'h1)) ? ST_DONE : ST_LOAD;
			ST_DONE: state_nxt = ST_DONE;
			default: state_nxt = ST_IDLE;
		endcase
	end
	genvar gi;
	generate
		for (gi = 0; gi < `FCL_NUM_FUSE; gi = gi + 1) begin : g_fuse
			always @(posedge MCLK or negedge rst_n_i) begin
				if (!rst_n_i) begin
					fuse_r[gi] <= 8'h00;
				end else if (state_r == ST_LOAD && idx_r == gi) begin
					fuse_r[gi] <= fuse_in;
				end
			end
		end
	endgenerate

	// ****************************************
	// write block qualification
	// ****************************************
	wire [7:0] sys0_fuse;
	reg pin_allows_block;
	reg block_qual;
	assign sys0_fuse = fuse_r[`FCL_IDX_SYS0];
	always @* begin
		case (sys0_fuse[3:2])
			`FCL_PIN_GPIO: pin_allows_block = 1'b1;
			`FCL_PIN_RESET: pin_allows_block = 1'b1;
			default: pin_allows_block = 1'b0;
		endcase
	end
	always @* begin
		block_qual = 1'b0;
		if (por_r && !sys0_fuse[`FCL_SYS0_BLOCK_OFF_BIT]) begin
			block_qual = pin_allows_block;
		end
	end

	// ****************************************
	// load control
	// ****************************************
	always @(posedge MCLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
			idx_r <= 4'h0;
			por_r <= 1'b0;
			block_start_r <= 1'b0;
			LOAD_DONE <= 1'b0;
		end else begin
			state_r <= state_nxt;
			block_start_r <= 1'b0;
			if (state_r == ST_IDLE) begin
				por_r <= POR_FLAG;
			end
			if (state_r == ST_LOAD) begin
				idx_r <= idx_r + 4'h1;
			end
			if (state_r == ST_LOAD && state_nxt == ST_DONE) begin
				LOAD_DONE <= 1'b1;
				block_start_r <= block_qual;
			end
		end
	end

	// ****************************************
	// peripheral fields
	// ****************************************
	reg load_done_q_r;
	wire apply;
	wire apply_por;
	wire [7:0] wdt_fuse;
	wire [7:0] bod_fuse;
	wire [7:0] osc_fuse;
	wire [7:0] tmr_fuse;
	assign wdt_fuse = fuse_r[`FCL_IDX_WDT];
	assign bod_fuse = fuse_r[`FCL_IDX_BOD];
	assign osc_fuse = fuse_r[`FCL_IDX_OSC];
	assign tmr_fuse = fuse_r[`FCL_IDX_TMR];
	assign apply = (state_r == ST_DONE) && !load_done_q_r;
	assign apply_por = apply && por_r;
	always @(posedge MCLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			load_done_q_r <= 1'b0;
		end else begin
			load_done_q_r <= LOAD_DONE;
		end
	end

	// ****************************************
	// retained brown-out and compare fields
	// ****************************************
	reg [2:0] bod_thr_nxt;
	reg bod_rate_nxt;
	reg [1:0] bod_act_nxt;
	reg [1:0] bod_slp_nxt;
	reg [3:0] cmp_en_nxt;
	reg [3:0] cmp_lvl_nxt;
	always @* begin
		bod_thr_nxt = BROWNOUT_THRESHOLD_SEL;
		bod_rate_nxt = BROWNOUT_SAMPLE_RATE;
		bod_act_nxt = BROWNOUT_ACTIVE_MODE;
		bod_slp_nxt = BROWNOUT_SLEEP_MODE;
		cmp_en_nxt = COMPARE_PIN_OUTPUT_ENABLE;
		cmp_lvl_nxt = COMPARE_DEFAULT_LEVEL;
		if (!rst_n_i && POR_FLAG) begin
			bod_thr_nxt = 3'h0;
			bod_rate_nxt = 1'b0;
			bod_act_nxt = 2'h0;
			bod_slp_nxt = 2'h0;
			cmp_en_nxt = 4'h0;
			cmp_lvl_nxt = 4'h0;
		end else if (apply_por) begin
			bod_thr_nxt = bod_fuse[7:5];
			bod_rate_nxt = bod_fuse[4];
			bod_act_nxt = bod_fuse[3:2];
			bod_slp_nxt = bod_fuse[1:0];
			cmp_en_nxt = tmr_fuse[7:4];
			cmp_lvl_nxt = tmr_fuse[3:0];
		end
	end
	// no asynchronous reset: a warm reset must leave these untouched
	always @(posedge MCLK) begin
		BROWNOUT_THRESHOLD_SEL <= bod_thr_nxt;
		BROWNOUT_SAMPLE_RATE <= bod_rate_nxt;
		BROWNOUT_ACTIVE_MODE <= bod_act_nxt;
		BROWNOUT_SLEEP_MODE <= bod_slp_nxt;
		COMPARE_PIN_OUTPUT_ENABLE <= cmp_en_nxt;
		COMPARE_DEFAULT_LEVEL <= cmp_lvl_nxt;
	end

	// ****************************************
	// fields reloaded on every reset
	// ****************************************
	reg [3:0] wdt_win_nxt;
	reg [3:0] wdt_per_nxt;
	reg trim_lock_nxt;
	reg [1:0] freq_sel_nxt;
	reg [1:0] scan_sel_nxt;
	reg [1:0] pin_fn_nxt;
	always @* begin
		wdt_win_nxt = WDT_WINDOW;
		wdt_per_nxt = WDT_PERIOD;
		trim_lock_nxt = RC_TRIM_LOCK;
		freq_sel_nxt = RC_FREQUENCY_SELECT;
		scan_sel_nxt = SCAN_SOURCE_SELECT;
		pin_fn_nxt = RESET_PIN_FUNCTION;
		if (apply) begin
			wdt_win_nxt = wdt_fuse[7:4];
			wdt_per_nxt = wdt_fuse[3:0];
			trim_lock_nxt = osc_fuse[7];
			freq_sel_nxt = osc_fuse[1:0];
			scan_sel_nxt = sys0_fuse[7:6];
			pin_fn_nxt = sys0_fuse[3:2];
		end
	end
	always @(posedge MCLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			WDT_WINDOW <= 4'h0;
			WDT_PERIOD <= 4'h0;
			RC_TRIM_LOCK <= 1'b0;
			RC_FREQUENCY_SELECT <= `FCL_RST_FREQ;
			SCAN_SOURCE_SELECT <= `FCL_RST_SCAN;
			RESET_PIN_FUNCTION <= `FCL_PIN_GPIO;
		end else begin
			WDT_WINDOW <= wdt_win_nxt;
			WDT_PERIOD <= wdt_per_nxt;
			RC_TRIM_LOCK <= trim_lock_nxt;
			RC_FREQUENCY_SELECT <= freq_sel_nxt;
			SCAN_SOURCE_SELECT <= scan_sel_nxt;
			RESET_PIN_FUNCTION <= pin_fn_nxt;
		end
	end

	// ****************************************
	// write block timing
	// ****************************************
	reg [12:0] div_r;
	reg slow_tick_r;
	localparam [12:0] DIV_LAST = SLOW_DIV - 1;
	always @(posedge MCLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_r <= 13'h0000;
			slow_tick_r <= 1'b0;
		end else if (div_r == DIV_LAST) begin
			div_r <= 13'h0000;
			slow_tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 13'h0001;
			slow_tick_r <= 1'b0;
		end
	end
	fcl_block_timer u_block (
		.clk(MCLK),
		.rst_n(rst_n_i),
		.start(block_start_r),
		.slow_tick(slow_tick_r),
		.busy_r(block_busy)
	);
	always @(posedge MCLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			NV_WRITE_BLOCK <= 1'b0;
		end else begin
			NV_WRITE_BLOCK <= block_busy || block_start_r;
		end
	end

	// ****************************************
	// wishbone slave
	// ****************************************
	wire req;
	wire [5:0] widx;
	reg [31:0] rdata;
	reg hit;
	assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
	assign widx = WB_ADR_I[7:2];
	always @* begin
		rdata = 32'h00000000;
		hit = 1'b0;
		case (widx)
			{2'h0, `FCL_IDX_WDT},
			{2'h0, `FCL_IDX_BOD},
			{2'h0, `FCL_IDX_OSC},
			{2'h0, `FCL_IDX_TMR},
			{2'h0, `FCL_IDX_SYS0},
			{2'h0, `FCL_IDX_SYS1},
			{2'h0, `FCL_IDX_APP},
			{2'h0, `FCL_IDX_BOOT},
			{2'h0, `FCL_IDX_LOCK}: begin
				rdata = {24'h000000, fuse_r[widx[3:0]]};
				hit = 1'b1;
			end
			{2'h0, `FCL_IDX_STAT}: begin
				rdata = {30'h00000000, NV_WRITE_BLOCK, LOAD_DONE};
				hit = 1'b1;
			end
			default: begin
				rdata = 32'h00000000;
				hit = 1'b0;
			end
		endcase
	end
	always @(posedge MCLK or negedge rst_n_i) begin
		if (!rst_n_i) begin
			WB_ACK_O <= 1'b0;
			WB_ERR_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= req && hit && !WB_WE_I;
			WB_ERR_O <= req && (!hit || WB_WE_I);
			WB_DAT_O <= (req && hit && !WB_WE_I) ? rdata : 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// [dv/fcl_periph_model.sv]
// Purpose: peripheral control registers that take the loader's fields
// Assumes: fields settle one cycle after load done rises
// Notes: nv_ok tells bench software when nonvolatile commands may go
`default_nettype none
module fcl_periph_model (
	input wire logic clk,
	input wire logic ld,
	input wire logic nv_blk,
	input wire logic [30:0] fld,
	output logic [30:0] cfg,
	output logic nv_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ld_q = 1'b0;
	always @(posedge clk) begin
		ld_q <= ld;
		if (ld_q)
			cfg <= fld;
	end
	assign nv_ok = !nv_blk;
endmodule
`default_nettype wire

// [dv/fcl_loader_assertions.sv]
// Purpose: timing checks on the fuse loader ports
// Assumes: fuse inputs held still from reset to load done
// Notes: bound to every loader instance
`include "fcl_regs.vh"
`default_nettype none
module fcl_loader_chk #(
	parameter SLOW_DIV = `FCL_SLOW_DIV
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic POR_FLAG,
	input wire logic LOAD_DONE,
	input wire logic NV_WRITE_BLOCK,
	input wire logic [7:0] FUSE_WDT,
	input wire logic [7:0] FUSE_BOD,
	input wire logic [7:0] FUSE_OSC,
	input wire logic [7:0] FUSE_TMR,
	input wire logic [7:0] FUSE_SYS0,
	input wire logic [3:0] WDT_WINDOW,
	input wire logic [3:0] WDT_PERIOD,
	input wire logic [2:0] BROWNOUT_THRESHOLD_SEL,
	input wire logic BROWNOUT_SAMPLE_RATE,
	input wire logic [1:0] BROWNOUT_ACTIVE_MODE,
	input wire logic [1:0] BROWNOUT_SLEEP_MODE,
	input wire logic RC_TRIM_LOCK,
	input wire logic [1:0] RC_FREQUENCY_SELECT,
	input wire logic [3:0] COMPARE_PIN_OUTPUT_ENABLE,
	input wire logic [3:0] COMPARE_DEFAULT_LEVEL,
	input wire logic [1:0] SCAN_SOURCE_SELECT,
	input wire logic [1:0] RESET_PIN_FUNCTION
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	logic [31:0] blk_cnt;
	always @(posedge MCLK or negedge RST_N)
		if (!RST_N)
			blk_cnt <= 32'h0;
		else
			blk_cnt <= NV_WRITE_BLOCK ? blk_cnt + 32'h1 : 32'h0;
	a_wdt_fields: assert property ($rose(LOAD_DONE)
		|=> {WDT_WINDOW, WDT_PERIOD} == FUSE_WDT) else $error("watchdog fields wrong");
	a_bod_fields: assert property ($rose(LOAD_DONE) && POR_FLAG
		|=> {BROWNOUT_THRESHOLD_SEL, BROWNOUT_SAMPLE_RATE, BROWNOUT_ACTIVE_MODE,
		BROWNOUT_SLEEP_MODE} == FUSE_BOD) else $error("brown-out fields wrong");
	a_osc_fields: assert property ($rose(LOAD_DONE)
		|=> {RC_TRIM_LOCK, RC_FREQUENCY_SELECT} == {FUSE_OSC[7], FUSE_OSC[1:0]})
		else $error("oscillator fields wrong");
	a_cmp_fields: assert property ($rose(LOAD_DONE) && POR_FLAG
		|=> {COMPARE_PIN_OUTPUT_ENABLE, COMPARE_DEFAULT_LEVEL} == FUSE_TMR)
		else $error("compare fields wrong");
	a_sys_fields: assert property ($rose(LOAD_DONE)
		|=> {SCAN_SOURCE_SELECT, RESET_PIN_FUNCTION} == {FUSE_SYS0[7:6], FUSE_SYS0[3:2]})
		else $error("system fields wrong");
	a_block_start: assert property ($rose(LOAD_DONE) && POR_FLAG && !FUSE_SYS0[4]
		&& (FUSE_SYS0[3:2] == `FCL_PIN_GPIO || FUSE_SYS0[3:2] == `FCL_PIN_RESET)
		|-> ##[1:3] NV_WRITE_BLOCK) else $error("block not started");
	a_bod_keep: assert property ($rose(LOAD_DONE) && !POR_FLAG
		|=> $stable({BROWNOUT_THRESHOLD_SEL, BROWNOUT_SAMPLE_RATE, BROWNOUT_ACTIVE_MODE,
		BROWNOUT_SLEEP_MODE, COMPARE_PIN_OUTPUT_ENABLE, COMPARE_DEFAULT_LEVEL}))
		else $error("retained fields reloaded");
	a_block_len: assert property ($fell(NV_WRITE_BLOCK)
		|-> blk_cnt >= (`FCL_BLOCK_SLOW_CYC - 1) * SLOW_DIV
		&& blk_cnt <= (`FCL_BLOCK_SLOW_CYC + 1) * SLOW_DIV) else $error("block length wrong");
	a_block_off: assert property ($rose(LOAD_DONE) && FUSE_SYS0[4]
		|=> !NV_WRITE_BLOCK [*3]) else $error("block active though disabled");
	a_fields_hold: assert property (LOAD_DONE [*3]
		|-> $stable({WDT_WINDOW, WDT_PERIOD, RC_TRIM_LOCK, SCAN_SOURCE_SELECT}))
		else $error("fields changed without reset");
	cover property ($rose(NV_WRITE_BLOCK));
	cover property ($rose(LOAD_DONE) && !POR_FLAG);
	cover property ($rose(LOAD_DONE) && FUSE_SYS0[4]);
endmodule
bind fcl_loader fcl_loader_chk #(.SLOW_DIV(SLOW_DIV)) chk (.*);
`default_nettype wire

// [dv/fcl_loader_tb.sv]
// Purpose: self-checking bench for the fuse loader
// Assumes: slow divider shortened to 2
// Notes: bus answers checked by a queue monitor
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end
module fcl_loader_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 0, RST_N = 0, POR_FLAG = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
	logic [7:0] WB_ADR_I = 8'h00, fu[11] = '{default: 8'h00}, bod0, tmr0;
	logic [3:0] WB_SEL_I = 4'hF;
	logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
	logic WB_ACK_O, WB_ERR_O, LOAD_DONE, RC_TRIM_LOCK, BROWNOUT_SAMPLE_RATE, NV_WRITE_BLOCK;
	logic [3:0] WDT_WINDOW, WDT_PERIOD, COMPARE_PIN_OUTPUT_ENABLE, COMPARE_DEFAULT_LEVEL;
	logic [2:0] BROWNOUT_THRESHOLD_SEL;
	logic [1:0] BROWNOUT_ACTIVE_MODE, BROWNOUT_SLEEP_MODE, RC_FREQUENCY_SELECT;
	logic [1:0] SCAN_SOURCE_SELECT, RESET_PIN_FUNCTION;
	logic [30:0] cfg, c0;
	logic nv_ok;
	logic [32:0] q[$], e;
	int n_fail = 0, checks_done = 0, seed = 32'hdd3c, k;
	wire logic [7:0] FUSE_WDT = fu[0], FUSE_BOD = fu[1], FUSE_OSC = fu[2], FUSE_TMR = fu[4];
	wire logic [7:0] FUSE_SYS0 = fu[5], FUSE_SYS1 = fu[6], FUSE_APP = fu[7], FUSE_BOOT = fu[8];
	wire logic [7:0] FUSE_LOCK = fu[10];
	fcl_loader #(.SLOW_DIV(2)) dut (.*);
	fcl_periph_model pm (.clk(MCLK), .ld(LOAD_DONE), .nv_blk(NV_WRITE_BLOCK), .fld({WDT_WINDOW,
		WDT_PERIOD, BROWNOUT_THRESHOLD_SEL, BROWNOUT_SAMPLE_RATE, BROWNOUT_ACTIVE_MODE,
		BROWNOUT_SLEEP_MODE, RC_TRIM_LOCK, RC_FREQUENCY_SELECT, COMPARE_PIN_OUTPUT_ENABLE,
		COMPARE_DEFAULT_LEVEL, SCAN_SOURCE_SELECT, RESET_PIN_FUNCTION}), .cfg(cfg), .nv_ok(nv_ok));
	initial forever #2.5 MCLK = ~MCLK;
	always @(posedge MCLK)
		if (WB_ACK_O | WB_ERR_O) begin
			e = q.pop_front();
			`CHK({WB_ERR_O, WB_DAT_O}, e)
		end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic rnd;
		logic [7:0] r;
		@(posedge MCLK);
		for (int i = 0; i < 11; i++) begin
			r = 8'($random(seed));
			fu[i] <= (i == 5) ? (r & 8'hE3) | 8'h08 : r;
		end
	endtask
	task automatic rst(input logic por);
		@(posedge MCLK);
		RST_N <= 0;
		POR_FLAG <= por;
		repeat (8) @(posedge MCLK);
		RST_N <= 1;
		k = 0;
		while (!LOAD_DONE && k < 100) begin
			@(posedge MCLK);
			k++;
		end
		`CHK(LOAD_DONE, 1'b1)
		repeat (3) @(negedge MCLK);
	endtask
	task automatic fields(input logic [7:0] b, input logic [7:0] t);
		@(negedge MCLK);
		`CHK(cfg, {fu[0], b, fu[2][7], fu[2][1:0], t, fu[5][7:6], fu[5][3:2]})
	endtask
	task automatic wb(input logic [7:0] a, input logic we, input logic [32:0] x);
		@(posedge MCLK);
		q.push_back(x);
		WB_CYC_I <= 1;
		WB_STB_I <= 1;
		WB_WE_I <= we;
		WB_ADR_I <= a;
		WB_DAT_I <= we ? $random(seed) : 32'h0;
		k = 0;
		do begin
			@(posedge MCLK);
			k++;
		end while (!(WB_ACK_O | WB_ERR_O) && k < 50);
		WB_CYC_I <= 0;
		WB_STB_I <= 0;
		WB_WE_I <= 0;
		if (k >= 50) begin
			n_fail++;
		end
	endtask
	initial begin
		repeat (20000) @(posedge MCLK);
		n_fail++;
		end_sim;
	end
	initial begin
		rnd;
		rst(1);
		fields(fu[1], fu[4]);
		for (int i = 0; i < 14; i++)
			if (i != 11 && i != 12)
				wb(8'(i * 4), 0, (i == 3 || i == 9 || i == 13) ? {1'b1, 32'h0} : {25'h0, fu[i % 11]});
		wb(8'h30, 0, {31'h0, 2'h3});
		wb(8'h04, 1, {1'b1, 32'h0});
		wb(8'h04, 0, {25'h0, fu[1]});
		k = 0;
		while (!nv_ok && k < 2000) begin
			@(posedge MCLK);
			k++;
		end
		`CHK({nv_ok, k > 1400}, 2'h3)
		$display("test por load done");
		bod0 = fu[1];
		tmr0 = fu[4];
		c0 = cfg;
		rnd;
		repeat (4) @(negedge MCLK);
		`CHK(cfg, c0)
		rst(0);
		fields(bod0, tmr0);
		`CHK(NV_WRITE_BLOCK, 1'b0)
		$display("test warm reset done");
		for (int i = 0; i < 8; i++) begin
			@(posedge MCLK);
			fu[5] <= {i[1:0], 1'b1, i[2], i[1:0], 2'b10};
			rst(1);
			fields(fu[1], fu[4]);
			`CHK(NV_WRITE_BLOCK, !i[2] && (i[1:0] == 2'h0 || i[1:0] == 2'h2))
		end
		$display("test block modes done");
		end_sim;
	end
endmodule
`default_nettype wire
